// >>> iam_decode.sv
`timescale 1ns/100ps
`default_nettype none

package iam_pkg;
	localparam logic [15:0] IAM_LIN_BASE  = 16'h2000;
	localparam logic [15:0] IAM_LIN_LAST  = 16'h2FEF;
	localparam logic [6:0]  IAM_LIN_BLK   = 7'h50;
	localparam logic [6:0]  IAM_GPR_FIRST = 7'h20;
	localparam logic [6:0]  IAM_GPR_LAST  = 7'h6F;
	localparam logic [5:0]  IAM_MAX_BANK  = 6'h32;
	localparam int          IAM_FLASH_BIT = 15;
	localparam int          IAM_FW_DEF    = 14;
	localparam int          IAM_BANKS_DEF = 4;
	localparam int          IAM_DATA_LAT  = 3;
	localparam int          IAM_FLASH_LAT = 4;
	localparam logic [7:0]  IAM_ZERO      = 8'h00;

	typedef enum logic [1:0] {
		IAM_TRAD,
		IAM_LIN,
		IAM_FLASH,
		IAM_NONE
	} iam_kind_type;
endpackage

module iam_decode import iam_pkg::*; #(
	parameter int NUM_BANKS = IAM_BANKS_DEF
) (
	input  wire logic [15:0] i_ptr,
	output iam_kind_type     o_kind,
	output logic [5:0]       o_bank,
	output logic [6:0]       o_ofs,
	output logic [14:0]      o_flash_addr
);
	logic [11:0] lin_idx;
	logic [5:0]  lin_bank;
	logic [6:0]  lin_ofs;
	logic        lin_impl;

	assign lin_idx      = i_ptr[11:0];
	assign lin_bank     = 6'(lin_idx / 12'(IAM_LIN_BLK));
	assign lin_ofs      = 7'(lin_idx % 12'(IAM_LIN_BLK)) + IAM_GPR_FIRST; // RQ4 RQ5
	assign lin_impl     = (lin_bank <= IAM_MAX_BANK)
		&& (32'(lin_bank) < NUM_BANKS); // RQ2
	assign o_flash_addr = i_ptr[14:0]; // RQ6

	always_comb begin
		o_bank = i_ptr[12:7]; // RQ10
		o_ofs  = i_ptr[6:0];
		if (i_ptr[IAM_FLASH_BIT]) begin
			o_kind = IAM_FLASH; // RQ6
		end else if (i_ptr < IAM_LIN_BASE) begin
			o_kind = IAM_TRAD; // RQ10
		end else if (i_ptr <= IAM_LIN_LAST && lin_impl) begin
			o_kind = IAM_LIN; // RQ1
			o_bank = lin_bank;
			o_ofs  = lin_ofs;
		end else begin
			o_kind = IAM_NONE; // RQ3
		end
	end
endmodule

`default_nettype wire

// >>> iam_mapper.sv
// Operation
// (RQ1) Linear range maps banks' 80-byte blocks contiguously
// (RQ2) Linear view limited to implemented banks, max 50
// (RQ3) Unimplemented linear reads return zero
// (RQ4) Last block byte steps to next bank's first
// (RQ5) Common memory never appears in linear view
// (RQ6) Pointer MSB set selects flash word address
// (RQ7) Flash reads return low eight bits only
// (RQ8) Writes to flash are ignored
// (RQ9) Flash access costs one extra cycle
// (RQ10) Below linear range: bank high, byte low
`timescale 1ns/100ps
`default_nettype none

module iam_mapper import iam_pkg::*; #(
	parameter int NUM_BANKS = IAM_BANKS_DEF,
	parameter int FW        = IAM_FW_DEF
) (
	input  wire logic          i_ref_clk,
	input  wire logic          i_sys_rst,
	input  wire logic          i_req,
	input  wire logic          i_we,
	input  wire logic [15:0]   i_ptr,
	input  wire logic [7:0]    i_wdata,
	input  wire logic [7:0]    i_ram_rdata,
	input  wire logic [FW-1:0] i_flash_rdata,
	output logic               o_busy,
	output logic               o_done,
	output logic [7:0]         o_rdata,
	output logic               o_ram_req,
	output logic               o_ram_we,
	output logic [5:0]         o_ram_bank,
	output logic [6:0]         o_ram_ofs,
	output logic [7:0]         o_ram_wdata,
	output logic               o_flash_req,
	output logic [14:0]        o_flash_addr
);
	typedef enum logic [1:0] {
		IAM_IDLE,
		IAM_ACC,
		IAM_LAT,
		IAM_XTRA
	} iam_state_type;

	iam_state_type state_r, state_nxt;
	iam_kind_type  kind_r, kind_nxt, dec_kind;
	logic          we_r, we_nxt;
	logic          busy_nxt, done_nxt;
	logic [7:0]    rdata_nxt;
	logic          ram_req_nxt, ram_we_nxt, flash_req_nxt;
	logic [5:0]    bank_nxt, dec_bank;
	logic [6:0]    ofs_nxt, dec_ofs;
	logic [7:0]    wdata_nxt;
	logic [14:0]   faddr_nxt, dec_faddr;
	logic          take;

	iam_decode #(
		.NUM_BANKS (NUM_BANKS)
	) u_decode (
		.i_ptr        (i_ptr),
		.o_kind       (dec_kind),
		.o_bank       (dec_bank),
		.o_ofs        (dec_ofs),
		.o_flash_addr (dec_faddr)
	);

	assign take = i_req && !o_busy;

	always_comb begin
		state_nxt     = state_r;
		kind_nxt      = kind_r;
		we_nxt        = we_r;
		done_nxt      = 1'b0;
		rdata_nxt     = o_rdata;
		ram_req_nxt   = 1'b0;
		ram_we_nxt    = 1'b0;
		flash_req_nxt = 1'b0;
		bank_nxt      = o_ram_bank;
		ofs_nxt       = o_ram_ofs;
		wdata_nxt     = o_ram_wdata;
		faddr_nxt     = o_flash_addr;
		unique case (state_r)
			IAM_IDLE: begin
				if (take) begin
					state_nxt = IAM_ACC;
					kind_nxt  = dec_kind;
					we_nxt    = i_we;
					bank_nxt  = dec_bank;
					ofs_nxt   = dec_ofs;
					wdata_nxt = i_wdata;
					faddr_nxt = dec_faddr;
					ram_req_nxt   = (dec_kind == IAM_TRAD) || (dec_kind == IAM_LIN); // RQ1 RQ10
					ram_we_nxt    = ram_req_nxt && i_we;
					flash_req_nxt = (dec_kind == IAM_FLASH) && !i_we; // RQ8
				end
			end
			IAM_ACC: begin
				state_nxt = IAM_LAT;
			end
			IAM_LAT: begin
				if (we_r || kind_r == IAM_NONE) begin
					rdata_nxt = IAM_ZERO; // RQ3
				end else if (kind_r == IAM_FLASH) begin
					rdata_nxt = i_flash_rdata[7:0]; // RQ7
				end else begin
					rdata_nxt = i_ram_rdata;
				end
				if (kind_r == IAM_FLASH) begin
					state_nxt = IAM_XTRA; // RQ9
				end else begin
					state_nxt = IAM_IDLE;
					done_nxt  = 1'b1;
				end
			end
			IAM_XTRA: begin
				state_nxt = IAM_IDLE;
				done_nxt  = 1'b1;
			end
		endcase
		busy_nxt = (state_nxt != IAM_IDLE);
	end

	always_ff @(posedge i_ref_clk) begin
		if (i_sys_rst) begin
			state_r      <= IAM_IDLE;
			kind_r       <= IAM_TRAD;
			we_r         <= 1'b0;
			o_busy       <= 1'b0;
			o_done       <= 1'b0;
			o_rdata      <= IAM_ZERO;
			o_ram_req    <= 1'b0;
			o_ram_we     <= 1'b0;
			o_ram_bank   <= 6'h00;
			o_ram_ofs    <= 7'h00;
			o_ram_wdata  <= IAM_ZERO;
			o_flash_req  <= 1'b0;
			o_flash_addr <= 15'h0000;
		end else begin
			state_r      <= state_nxt;
			kind_r       <= kind_nxt;
			we_r         <= we_nxt;
			o_busy       <= busy_nxt;
			o_done       <= done_nxt;
			o_rdata      <= rdata_nxt;
			o_ram_req    <= ram_req_nxt;
			o_ram_we     <= ram_we_nxt;
			o_ram_bank   <= bank_nxt;
			o_ram_ofs    <= ofs_nxt;
			o_ram_wdata  <= wdata_nxt;
			o_flash_req  <= flash_req_nxt;
			o_flash_addr <= faddr_nxt;
		end
	end

	sequence take_flash_s;
		take && i_ptr[IAM_FLASH_BIT];
	endsequence

	sequence take_lin_s;
		take && !i_ptr[IAM_FLASH_BIT] && i_ptr >= IAM_LIN_BASE && i_ptr <= IAM_LIN_LAST
			&& dec_kind == IAM_LIN;
	endsequence

	sequence take_data_s;
		take && !i_ptr[IAM_FLASH_BIT];
	endsequence

	lin_map_a: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst) // RQ1
		take_lin_s |=> o_ram_req
			&& (12'(o_ram_bank) * 12'(IAM_LIN_BLK) + 12'(o_ram_ofs - IAM_GPR_FIRST))
			== $past(i_ptr[11:0]))
		else $error("linear address mapped to wrong bank or byte");

	lin_limit_a: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst) // RQ2
		take_lin_s |=> o_ram_bank <= IAM_MAX_BANK && 32'(o_ram_bank) < NUM_BANKS)
		else $error("linear access beyond implemented banks");

	unimpl_zero_a: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst) // RQ3
		take && !i_we && dec_kind == IAM_NONE
			|=> !o_ram_req ##2 o_done && o_rdata == IAM_ZERO)
		else $error("unimplemented read did not return zero");

	bank_step_a: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst) // RQ4
		take_lin_s ##0 (7'(i_ptr[11:0] % 12'(IAM_LIN_BLK)) == IAM_LIN_BLK - 7'h01)
			|=> o_ram_ofs == IAM_GPR_LAST)
		else $error("block end not at last general purpose byte");

	bank_wrap_a: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst) // RQ4
		take_lin_s ##0 (i_ptr[11:0] % 12'(IAM_LIN_BLK) == 12'h000)
			|=> o_ram_ofs == IAM_GPR_FIRST
			&& 12'(o_ram_bank) * 12'(IAM_LIN_BLK) == $past(i_ptr[11:0]))
		else $error("block start not at next bank first byte");

	no_common_a: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst) // RQ5
		take_lin_s |=> o_ram_ofs >= IAM_GPR_FIRST && o_ram_ofs <= IAM_GPR_LAST)
		else $error("linear view reached common memory");

	flash_addr_a: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst) // RQ6
		take_flash_s ##0 !i_we |=> o_flash_req && !o_ram_req
			&& o_flash_addr == $past(i_ptr[14:0]))
		else $error("flash word address not issued");

	flash_byte_a: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst) // RQ7
		take_flash_s ##0 !i_we |-> ##4 o_done && o_rdata == $past(i_flash_rdata[7:0], 2))
		else $error("flash read not low byte of word");

	flash_ro_a: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst) // RQ8
		take_flash_s ##0 i_we |=> !o_flash_req && !o_ram_req && !o_ram_we)
		else $error("write reached a memory from flash space");

	flash_extra_a: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst) // RQ9
		take_flash_s |=> o_busy [*3] ##1 o_done && !o_busy)
		else $error("flash access timing not one extra cycle");

	data_time_a: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst) // RQ9
		take_data_s |=> o_busy [*2] ##1 o_done && !o_busy)
		else $error("data access timing wrong");

	trad_map_a: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst) // RQ10
		take && i_ptr < IAM_LIN_BASE |=> o_ram_req && o_ram_we == $past(i_we)
			&& {o_ram_bank, o_ram_ofs} == $past(i_ptr[12:0]))
		else $error("banked address decode wrong");
endmodule

`default_nettype wire

// >>> iam_mem_model.sv
`timescale 1ns/100ps
`default_nettype none

module iam_mem_model (
	input  wire logic        i_ref_clk,
	input  wire logic        i_sys_rst,
	input  wire logic        i_ram_req,
	input  wire logic        i_ram_we,
	input  wire logic [5:0]  i_ram_bank,
	input  wire logic [6:0]  i_ram_ofs,
	input  wire logic [7:0]  i_ram_wdata,
	input  wire logic        i_flash_req,
	input  wire logic [14:0] i_flash_addr,
	output logic      [7:0]  o_ram_rdata,
	output logic      [13:0] o_flash_rdata
);
	logic [7:0] mem [0:8191];

	// Read data valid one cycle after strobe, toggles otherwise
	always_ff @(posedge i_ref_clk) begin
		if (i_ram_req && i_ram_we) begin
			mem[{i_ram_bank, i_ram_ofs}] <= i_ram_wdata;
		end
		if (i_sys_rst) begin
			o_ram_rdata   <= 8'h00;
			o_flash_rdata <= 14'h0000;
		end else begin
			o_ram_rdata   <= (i_ram_req && !i_ram_we) ?
				mem[{i_ram_bank, i_ram_ofs}] : ~o_ram_rdata;
			o_flash_rdata <= i_flash_req ?
				{i_flash_addr[5:0], i_flash_addr[7:0] ^ 8'hA5} : ~o_flash_rdata;
		end
	end
endmodule

`default_nettype wire

// >>> indirect_address_mapper_tb.sv
`timescale 1ns/100ps
`default_nettype none

module indirect_address_mapper_tb;
	logic        clk = 1'b0;
	logic        rst = 1'b1;
	logic        req = 1'b0;
	logic        we  = 1'b0;
	logic [15:0] ptr = 16'h0000;
	logic [7:0]  wd  = 8'h00;
	logic        busy, done, ram_req, ram_we, fl_req;
	logic [7:0]  rdata, ram_wd, ram_rd, rd;
	logic [5:0]  bank;
	logic [6:0]  ofs;
	logic [14:0] fl_addr;
	logic [13:0] fl_rd;
	int          fail_count = 0;
	int          check_count = 0;
	int          lat, stb;

	always #25 clk = ~clk;

	iam_mapper #(.NUM_BANKS(4), .FW(14)) DUT (.i_ref_clk(clk), .i_sys_rst(rst),
		.i_req(req), .i_we(we), .i_ptr(ptr), .i_wdata(wd), .i_ram_rdata(ram_rd),
		.i_flash_rdata(fl_rd), .o_busy(busy), .o_done(done), .o_rdata(rdata),
		.o_ram_req(ram_req), .o_ram_we(ram_we), .o_ram_bank(bank), .o_ram_ofs(ofs),
		.o_ram_wdata(ram_wd), .o_flash_req(fl_req), .o_flash_addr(fl_addr));

	iam_mem_model MEM (.i_ref_clk(clk), .i_sys_rst(rst), .i_ram_req(ram_req),
		.i_ram_we(ram_we), .i_ram_bank(bank), .i_ram_ofs(ofs), .i_ram_wdata(ram_wd),
		.i_flash_req(fl_req), .i_flash_addr(fl_addr), .o_ram_rdata(ram_rd),
		.o_flash_rdata(fl_rd));

	task automatic close_out();
		$display("checks %0d errors %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	task automatic chk8(input string nm, input logic [7:0] e, input logic [7:0] g);
		check_count++;
		if (g !== e) begin
			fail_count++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic chkn(input string nm, input int e, input int g);
		check_count++;
		if (g != e) begin
			fail_count++;
			$display("ERROR %s expected %0d seen %0d", nm, e, g);
		end
	endtask

	// Called at a falling edge; returns at the falling edge showing done
	task automatic acc(input logic w, input logic [15:0] p, input logic [7:0] d);
		int n;
		n = 0;
		stb = 0;
		req = 1'b1;
		we = w;
		ptr = p;
		wd = d;
		@(negedge clk);
		req = 1'b0;
		while (done !== 1'b1 && n < 10) begin
			stb += (ram_req === 1'b1) + (fl_req === 1'b1);
			@(negedge clk);
			n++;
		end
		if (n >= 10) begin
			fail_count++;
			$display("ERROR done timeout");
			close_out();
		end else begin
			rd = rdata;
			lat = n + 1;
		end
	endtask

	task automatic t_linear();
		acc(1'b1, 16'h0070, 8'h99);
		acc(1'b1, 16'h204F, 8'hC3);
		acc(1'b1, 16'h2050, 8'h5A);
		acc(1'b0, 16'h006F, 8'h00);
		chk8("bank0 last gp byte", 8'hC3, rd);
		acc(1'b0, 16'h00A0, 8'h00);
		chk8("bank1 first gp byte", 8'h5A, rd);
		acc(1'b0, 16'h2050, 8'h00);
		chk8("linear skips common", 8'h5A, rd);
		chkn("data latency", iam_pkg::IAM_DATA_LAT, lat);
	endtask

	task automatic t_unimpl();
		acc(1'b1, 16'h213F, 8'h3C);
		acc(1'b1, 16'h2140, 8'hEE);
		chkn("unimplemented write strobes", 0, stb);
		acc(1'b0, 16'h01EF, 8'h00);
		chk8("last implemented byte", 8'h3C, rd);
		acc(1'b0, 16'h2140, 8'h00);
		chk8("unimplemented read", 8'h00, rd);
		acc(1'b0, 16'h213F, 8'h00);
		chk8("last implemented linear byte", 8'h3C, rd);
		acc(1'b0, 16'h2FF0, 8'h00);
		chk8("beyond linear read", 8'h00, rd);
	endtask

	task automatic t_flash();
		acc(1'b0, 16'h8123, 8'h00);
		chk8("flash low byte", 8'h86, rd);
		chkn("flash latency", iam_pkg::IAM_FLASH_LAT, lat);
		acc(1'b0, 16'hFFFF, 8'h00);
		chk8("flash top word", 8'h5A, rd);
		acc(1'b1, 16'h8123, 8'h11);
		chkn("flash write strobes", 0, stb);
		chk8("flash write result", 8'h00, rd);
		chkn("flash write latency", iam_pkg::IAM_FLASH_LAT, lat);
	endtask

	initial begin
		repeat (6) @(negedge clk);
		rst = 1'b0;
		chk8("busy after reset", 8'h00, {7'h00, busy});
		t_linear();
		t_unimpl();
		t_flash();
		close_out();
	end
endmodule

`default_nettype wire
